// ==== bench/oscsel_tb.sv ====
// Self-checking bench for the oscillator source select control block.
`timescale 1ns/100ps
module tb import oscsel_pkg::*; ();
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [2:0] initial_source_config, cur_src;
    logic secondary_input_kind, pll_locked_in, clock_fail_detect;
    logic secondary_osc_enable, secondary_drive_level;
    logic [7:0] osc_select, clock_divider_ctrl;
    logic [5:0] rc_trim_ctrl;
    int n_errors = 0;
    int n_tests = 0;

    oscsel_ctrl dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .initial_source_config(initial_source_config), .secondary_input_kind(secondary_input_kind),
        .pll_locked_in(pll_locked_in), .clock_fail_detect(clock_fail_detect), .osc_select(osc_select),
        .secondary_osc_enable(secondary_osc_enable), .secondary_drive_level(secondary_drive_level),
        .clock_divider_ctrl(clock_divider_ctrl), .rc_trim_ctrl(rc_trim_ctrl), .irq(irq));

    always #10 ref_clk = ~ref_clk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // The master holds the request until pready is seen high, so wait states would be honoured.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 32'h1, "pready");
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask

    function automatic logic [31:0] cw(input logic [2:0] q, input logic [7:0] lo);
        return {21'h0, q, lo};
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [31:0] r;
        rd(OSC_CTRL_ADDR, r);
        chk(r, 32'h0000_2200, "ctrl reset");
        rd(CLK_DIV_ADDR, r);
        chk(r, 32'(DIV_RESET) << DIV_LSB, "div reset");
        rd(RC_TRIM_ADDR, r);
        chk(r, 32'(TRIM_RESET), "trim reset");
        chk(32'(osc_select), 32'h04, "select reset");
    endtask

    task automatic t_regs;
        logic [31:0] r;
        wr(CLK_DIV_ADDR, 32'h0000_A500);
        rd(CLK_DIV_ADDR, r);
        chk(r, 32'h0000_A500, "div rw");
        chk(32'(clock_divider_ctrl), 32'hA5, "div out");
        wr(RC_TRIM_ADDR, 32'h0000_003F);
        rd(RC_TRIM_ADDR, r);
        chk(r, 32'h3F, "trim rw");
        chk(32'(rc_trim_ctrl), 32'h3F, "trim out");
    endtask

    task automatic t_switch(input logic [2:0] code);
        logic [31:0] r, m;
        int n;
        m = (code == 3'h1 || code == 3'h3) ? 32'h20 : 32'h0;
        wr(OSC_CTRL_ADDR, cw(code, 8'h01));
        n = 0;
        do begin
            rd(OSC_CTRL_ADDR, r);
            n++;
            if (r[SWITCH_BIT] === 1'b1) begin
                chk(32'(r[14:12]), 32'(cur_src), "cur while busy");
                chk(32'(r[PLL_LOCK_BIT]), 32'h0, "lock while busy");
            end
        end while (r[SWITCH_BIT] !== 1'b0 && n < 40);
        cur_src = code;
        chk(r, {17'h0, code, 1'b0, code, 8'h00} | m, "switch done");
        @(negedge ref_clk);
        chk(32'(osc_select), 32'h1 << code, "select");
        rd(SRC_STAT_ADDR, r);
        chk(r, 32'h1 << code, "source status");
        if (m != 0) begin
            @(posedge ref_clk);
            pll_locked_in <= 1'b0;
            rd(OSC_CTRL_ADDR, r);
            chk(32'(r[PLL_LOCK_BIT]), 32'h0, "pll unlock shown");
            @(posedge ref_clk);
            pll_locked_in <= 1'b1;
        end
        rd(IRQ_STAT_ADDR, r);
        chk(32'(r[IRQ_SWITCH_DONE]), 32'h1, "done status");
        chk(32'(r[IRQ_PLL_LOCK]), 32'(m != 0), "pll lock status");
        chk(32'(irq), 32'h0, "irq masked");
        wr(IRQ_CLR_ADDR, 32'h5);
    endtask

    task automatic t_fail;
        logic [31:0] r;
        @(posedge ref_clk);
        clock_fail_detect <= 1'b1;
        @(posedge ref_clk);
        clock_fail_detect <= 1'b0;
        rd(OSC_CTRL_ADDR, r);
        chk(32'(r[FAIL_BIT]), 32'h1, "fail set");
        wr(IRQ_EN_ADDR, 32'h2);
        @(negedge ref_clk);
        chk(32'(irq), 32'h1, "irq on");
        rd(IRQ_EN_ADDR, r);
        chk(r, 32'h2, "enable rw");
        wr(IRQ_EN_ADDR, 32'h0);
        @(negedge ref_clk);
        chk(32'(irq), 32'h0, "irq mask");
        wr(IRQ_EN_ADDR, 32'h2);
        wr(IRQ_CLR_ADDR, 32'h2);
        @(negedge ref_clk);
        chk(32'(irq), 32'h0, "irq clear");
        wr(OSC_CTRL_ADDR, cw(cur_src, 8'h00));
        rd(OSC_CTRL_ADDR, r);
        chk(32'(r[FAIL_BIT]), 32'h0, "fail cleared");
        wr(OSC_CTRL_ADDR, cw(cur_src, 8'h08));
        rd(OSC_CTRL_ADDR, r);
        chk(32'(r[FAIL_BIT]), 32'h0, "fail not set by sw");
        wr(IRQ_EN_ADDR, 32'h0);
    endtask

    task automatic t_drive;
        logic [31:0] r;
        logic e;
        wr(OSC_CTRL_ADDR, cw(cur_src, 8'h06));
        @(negedge ref_clk);
        chk({30'h0, secondary_osc_enable, secondary_drive_level}, 32'h2, "digital input");
        @(posedge ref_clk);
        secondary_input_kind <= 1'b1;
        @(negedge ref_clk);
        chk({30'h0, secondary_osc_enable, secondary_drive_level}, 32'h3, "crystal");
        apb(1'b1, 12'h01C, 32'hFFFF_FFFF, r, e);
        chk(32'(e), 32'h1, "unmapped write err");
        apb(1'b0, 12'h01C, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1, "unmapped read");
        apb(1'b0, IRQ_EN_ADDR, 32'h0, r, e);
        chk({r[30:0], e}, 32'h0, "mapped read");
    endtask

    // Lock runs last because only a reset can clear it again.
    task automatic t_lock;
        logic [31:0] r;
        logic [2:0] other;
        other = cur_src ^ 3'h3;
        wr(OSC_CTRL_ADDR, cw(cur_src, 8'h80));
        wr(OSC_CTRL_ADDR, cw(cur_src, 8'h00));
        rd(OSC_CTRL_ADDR, r);
        chk(32'(r[LOCK_BIT]), 32'h1, "lock sticky");
        wr(OSC_CTRL_ADDR, cw(other, 8'h01));
        repeat (SWITCH_CYC + 5) @(posedge ref_clk);
        rd(OSC_CTRL_ADDR, r);
        chk(32'(r[14:12]), 32'(cur_src), "locked switch");
        chk(32'(osc_select), 32'h1 << cur_src, "locked select");
    endtask

    // ------------------------------------------------------------
    // Main
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        initial_source_config = 3'h2;
        cur_src = 3'h2;
        secondary_input_kind = 1'b0;
        pll_locked_in = 1'b1;
        clock_fail_detect = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_regs();
        for (int c = 0; c < 8; c++) begin
            t_switch(3'(c));
        end
        t_fail();
        t_drive();
        t_lock();
        finish_test();
    end

    initial begin
        #200000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end
endmodule

// ==== rtl/oscsel_apb_decode.sv ====
// APB address decoder for the oscillator control register map.
`timescale 1ns/100ps
module oscsel_apb_decode
    import oscsel_pkg::*;
(
    input wire logic [11:0] paddr,
    output logic [6:0] sel,
    output logic hit
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb begin
        sel = 7'h00;
        if (paddr == OSC_CTRL_ADDR) begin
            sel[0] = 1'b1;
        end else if (paddr == CLK_DIV_ADDR) begin
            sel[1] = 1'b1;
        end else if (paddr == RC_TRIM_ADDR) begin
            sel[2] = 1'b1;
        end else if (paddr == SRC_STAT_ADDR) begin
            sel[3] = 1'b1;
        end else if (paddr == IRQ_STAT_ADDR) begin
            sel[4] = 1'b1;
        end else if (paddr == IRQ_EN_ADDR) begin
            sel[5] = 1'b1;
        end else if (paddr == IRQ_CLR_ADDR) begin
            sel[6] = 1'b1;
        end
    end
    assign hit = |sel;
endmodule

// ==== rtl/oscsel_ctrl.sv ====
// Oscillator source select control with APB registers and interrupt.
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/100ps
module oscsel_ctrl
    import oscsel_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] initial_source_config,
    input wire logic secondary_input_kind,
    input wire logic pll_locked_in,
    input wire logic clock_fail_detect,
    output logic [7:0] osc_select,
    output logic secondary_osc_enable,
    output logic secondary_drive_level,
    output logic [7:0] clock_divider_ctrl,
    output logic [5:0] rc_trim_ctrl,
    output logic irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum {SW_IDLE, SW_WAIT} oscsel_sw_t;

    typedef struct packed {
        logic init_done;
        logic [2:0] cur_src;
        logic [2:0] req_src;
        logic lock;
        logic pll_lock;
        logic fail;
        logic drive;
        logic sec_en;
        logic sw_req;
        logic [7:0] div;
        logic [5:0] trim;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic [SW_CNT_W-1:0] cnt;
        logic [31:0] rdata;
        logic sw_busy;
    } oscsel_state_t;

    oscsel_state_t s_q, s_d;
    oscsel_sw_t sw_q, sw_d;
    logic [6:0] sel;
    logic hit;
    logic wr_en, rd_en;
    logic [15:0] ctrl_word;
    logic [7:0] dec_onehot;
    logic dec_pll;
    logic [IRQ_W-1:0] ev;

    oscsel_apb_decode u_dec (
        .paddr(paddr),
        .sel(sel),
        .hit(hit)
    );

    oscsel_src_decode u_src (
        .src(s_q.cur_src),
        .onehot(dec_onehot),
        .pll_used(dec_pll)
    );

    // ------------------------------------------------------------
    // Bus
    // ------------------------------------------------------------
    // Zero wait states keep software polling on the switch bit cheap.
    assign pready = 1'b1;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !hit;

    always_comb begin
        ctrl_word = 16'h0000;
        ctrl_word[CUR_SRC_LSB +: 3] = s_q.cur_src;
        ctrl_word[REQ_SRC_LSB +: 3] = s_q.req_src;
        ctrl_word[LOCK_BIT] = s_q.lock;
        ctrl_word[PLL_LOCK_BIT] = s_q.pll_lock;
        ctrl_word[FAIL_BIT] = s_q.fail;
        ctrl_word[DRIVE_BIT] = s_q.drive;
        ctrl_word[SEC_EN_BIT] = s_q.sec_en;
        ctrl_word[SWITCH_BIT] = s_q.sw_req;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        sw_d = sw_q;
        ev = '0;
        if (!s_q.init_done) begin
            s_d.req_src = initial_source_config;
            s_d.cur_src = initial_source_config;
            s_d.init_done = 1'b1;
        end
        if (wr_en && sel[0]) begin
            s_d.req_src = pwdata[REQ_SRC_LSB +: 3];
            s_d.lock = s_q.lock | pwdata[LOCK_BIT];
            s_d.fail = s_q.fail & pwdata[FAIL_BIT];
            s_d.drive = pwdata[DRIVE_BIT];
            s_d.sec_en = pwdata[SEC_EN_BIT];
            if (pwdata[SWITCH_BIT] && !s_q.lock) begin
                s_d.sw_req = 1'b1;
            end
        end
        if (wr_en && sel[1]) begin
            s_d.div = pwdata[DIV_LSB +: 8];
        end
        if (wr_en && sel[2]) begin
            s_d.trim = pwdata[5:0];
        end
        if (wr_en && sel[5]) begin
            s_d.irq_en = pwdata[IRQ_W-1:0];
        end
        case (sw_q)
            SW_IDLE: begin
                s_d.sw_busy = 1'b0;
                if (s_q.sw_req) begin
                    sw_d = SW_WAIT;
                    s_d.cnt = SW_CNT_W'(SWITCH_CYC - 1);
                    s_d.sw_busy = 1'b1;
                end
            end
            default: begin
                if (s_q.cnt == '0) begin
                    s_d.cur_src = s_q.req_src;
                    s_d.sw_req = 1'b0;
                    s_d.sw_busy = 1'b0;
                    ev[IRQ_SWITCH_DONE] = 1'b1;
                    sw_d = SW_IDLE;
                end else begin
                    s_d.cnt = s_q.cnt - 1'b1;
                end
            end
        endcase
        if (s_d.sw_busy || !oscsel_uses_pll(s_d.cur_src)) begin
            s_d.pll_lock = 1'b0;
        end else begin
            s_d.pll_lock = pll_locked_in;
        end
        ev[IRQ_PLL_LOCK] = s_d.pll_lock && !s_q.pll_lock;
        if (clock_fail_detect) begin
            s_d.fail = 1'b1;
            ev[IRQ_FAIL] = !s_q.fail;
        end
        if (wr_en && sel[6]) begin
            s_d.irq_stat = s_q.irq_stat & ~pwdata[IRQ_W-1:0];
        end
        s_d.irq_stat = s_d.irq_stat | ev;
        s_d.rdata = s_q.rdata;
        if (rd_en) begin
            if (sel[0]) begin
                s_d.rdata = {16'h0000, ctrl_word};
            end else if (sel[1]) begin
                s_d.rdata = {16'h0000, s_q.div, 8'h00};
            end else if (sel[2]) begin
                s_d.rdata = {26'h0, s_q.trim};
            end else if (sel[3]) begin
                s_d.rdata = {24'h000000, dec_onehot};
            end else if (sel[4]) begin
                s_d.rdata = {29'h0, s_q.irq_stat};
            end else if (sel[5]) begin
                s_d.rdata = {29'h0, s_q.irq_en};
            end else begin
                s_d.rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.div <= DIV_RESET;
            s_q.trim <= TRIM_RESET;
            sw_q <= SW_IDLE;
        end else begin
            s_q <= s_d;
            sw_q <= sw_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = s_q.rdata;
    assign osc_select = dec_onehot;
    assign secondary_osc_enable = s_q.sec_en;
    // Digital clock input has no crystal to drive, so the level is masked.
    assign secondary_drive_level = s_q.drive & secondary_input_kind;
    assign clock_divider_ctrl = s_q.div;
    assign rc_trim_ctrl = s_q.trim;
    assign irq = |(s_q.irq_stat & s_q.irq_en);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_lock_sticky;
        @(posedge ref_clk) disable iff (!rst_n) s_q.lock |=> s_q.lock;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("switch lock cleared");

    property p_fail_set;
        @(posedge ref_clk) disable iff (!rst_n) clock_fail_detect |=> s_q.fail;
    endproperty
    a_fail_set: assert property (p_fail_set) else $error("fail flag not set");

    property p_fail_no_sw_set;
        @(posedge ref_clk) disable iff (!rst_n) !s_q.fail && !clock_fail_detect |=> !s_q.fail;
    endproperty
    a_fail_no_sw_set: assert property (p_fail_no_sw_set) else $error("fail flag set by software");

    property p_pll_clear;
        @(posedge ref_clk) disable iff (!rst_n) !oscsel_uses_pll(s_q.cur_src) || s_q.sw_busy |-> !s_q.pll_lock;
    endproperty
    a_pll_clear: assert property (p_pll_clear) else $error("pll lock shown without pll");

    property p_switch_done;
        @(posedge ref_clk) disable iff (!rst_n)
            $rose(s_q.sw_req) |-> s_q.sw_req [*2] ##[1:20] (!s_q.sw_req && s_q.cur_src == s_q.req_src);
    endproperty
    a_switch_done: assert property (p_switch_done) else $error("switch did not complete");

    property p_locked_no_switch;
        @(posedge ref_clk) disable iff (!rst_n) s_q.lock && !s_q.sw_req |=> !s_q.sw_req;
    endproperty
    a_locked_no_switch: assert property (p_locked_no_switch) else $error("switch while locked");

    property p_cur_stable;
        @(posedge ref_clk) disable iff (!rst_n) s_q.init_done && sw_q == SW_IDLE |=> $stable(s_q.cur_src);
    endproperty
    a_cur_stable: assert property (p_cur_stable) else $error("current source moved without switch");

    property p_init_load;
        @(posedge ref_clk) disable iff (!rst_n) !s_q.init_done |=> s_q.req_src == $past(initial_source_config);
    endproperty
    a_init_load: assert property (p_init_load) else $error("request not loaded from config");

    property p_drive_mask;
        @(posedge ref_clk) disable iff (!rst_n) !secondary_input_kind |-> !secondary_drive_level;
    endproperty
    a_drive_mask: assert property (p_drive_mask) else $error("drive active on digital input");

    c_switch: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(s_q.sw_req));
    c_fail: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(s_q.fail));
    c_irq: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(irq));
endmodule

// ==== rtl/oscsel_src_decode.sv ====
// One-hot decoder that turns a source code into oscillator select lines.
`timescale 1ns/100ps
module oscsel_src_decode
    import oscsel_pkg::*;
(
    input wire logic [2:0] src,
    output logic [7:0] onehot,
    output logic pll_used
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb begin
        onehot = 8'h00;
        case (src)
            OSCSEL_FAST_RC: onehot[0] = 1'b1;
            OSCSEL_FAST_RC_WITH_PLL: onehot[1] = 1'b1;
            OSCSEL_PRIMARY: onehot[2] = 1'b1;
            OSCSEL_PRIMARY_PLL: onehot[3] = 1'b1;
            OSCSEL_SECONDARY_OSC: onehot[4] = 1'b1;
            OSCSEL_LOW_POWER_RC_OSC: onehot[5] = 1'b1;
            OSCSEL_LOW_POWER_FAST_RC_POSTSCALED: onehot[6] = 1'b1;
            default: onehot[7] = 1'b1;
        endcase
    end
    assign pll_used = oscsel_uses_pll(src);
endmodule

// ==== shared/oscsel_pkg.sv ====
// Package with register map, field layout and timing constants of the oscillator control block.
package oscsel_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] OSC_CTRL_ADDR = 12'h000;
    localparam logic [11:0] CLK_DIV_ADDR = 12'h004;
    localparam logic [11:0] RC_TRIM_ADDR = 12'h008;
    localparam logic [11:0] SRC_STAT_ADDR = 12'h00C;
    localparam logic [11:0] IRQ_STAT_ADDR = 12'h010;
    localparam logic [11:0] IRQ_EN_ADDR = 12'h014;
    localparam logic [11:0] IRQ_CLR_ADDR = 12'h018;

    // ------------------------------------------------------------
    // Oscillator control field positions
    // ------------------------------------------------------------
    localparam int CUR_SRC_LSB = 12;
    localparam int REQ_SRC_LSB = 8;
    localparam int LOCK_BIT = 7;
    localparam int PLL_LOCK_BIT = 5;
    localparam int FAIL_BIT = 3;
    localparam int DRIVE_BIT = 2;
    localparam int SEC_EN_BIT = 1;
    localparam int SWITCH_BIT = 0;

    // ------------------------------------------------------------
    // Divider and trim fields and reset values
    // ------------------------------------------------------------
    localparam int DIV_LSB = 8;
    localparam logic [7:0] DIV_RESET = 8'h31;
    localparam logic [5:0] TRIM_RESET = 6'h00;

    // ------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------
    localparam int IRQ_SWITCH_DONE = 0;
    localparam int IRQ_FAIL = 1;
    localparam int IRQ_PLL_LOCK = 2;
    localparam int IRQ_W = 3;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int SWITCH_TIME_NS = 200;
    localparam int SWITCH_CYC = (SWITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SW_CNT_W = 4;

    // ------------------------------------------------------------
    // Source encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OSCSEL_FAST_RC = 3'h0,
        OSCSEL_FAST_RC_WITH_PLL = 3'h1,
        OSCSEL_PRIMARY = 3'h2,
        OSCSEL_PRIMARY_PLL = 3'h3,
        OSCSEL_SECONDARY_OSC = 3'h4,
        OSCSEL_LOW_POWER_RC_OSC = 3'h5,
        OSCSEL_LOW_POWER_FAST_RC_POSTSCALED = 3'h6,
        OSCSEL_FAST_RC_POSTSCALED = 3'h7
    } oscsel_src_t;

    function automatic logic oscsel_uses_pll(input logic [2:0] src);
        return (src == OSCSEL_FAST_RC_WITH_PLL) || (src == OSCSEL_PRIMARY_PLL);
    endfunction

endpackage
